// ### verilog/fpcc_consts.vh
// Constants for the floating-point compare and ceiling-convert slice
`ifndef FPCC_CONSTS_VH
`define FPCC_CONSTS_VH

// Instruction fields
`define FPCC_OPC_COPROC_ONE    6'h11
`define FPCC_FMT_SINGLE        5'h10
`define FPCC_FMT_DOUBLE        5'h11
`define FPCC_FUNC_CEIL_LONG    6'h0a
`define FPCC_FUNC_CEIL_WORD    6'h0e
`define FPCC_CMP_TAG           2'h3
`define FPCC_CMP_ZERO          2'h0

// Register byte offsets on the AXI4-Lite slave
`define FPCC_ADDR_CSR          4'h0
`define FPCC_ADDR_CONDS        4'h4

// Control/status field positions
`define FPCC_CSR_INEXACT_FLAG  0
`define FPCC_CSR_INVALID_FLAG  1
`define FPCC_CSR_UNIMPL_FLAG   2
`define FPCC_CSR_INVALID_EN    8
`define FPCC_CSR_COND0         23

// Reset values
`define FPCC_CSR_RESET         1'b0
`define FPCC_CONDS_RESET       8'h00

// Bus answers
`define FPCC_RESP_OKAY         2'h0
`define FPCC_RESP_SLVERR       2'h2

// Default results of an invalid conversion and the range limits that flag it
`define FPCC_LONG_MAX          64'h7fffffffffffffff
`define FPCC_WORD_MAX          64'h000000007fffffff
`define FPCC_LONG_LIMIT        66'h08000000000000000
`define FPCC_WORD_LIMIT        66'h00000000080000000

// Exponent biases
`define FPCC_BIAS_DOUBLE       13'h03ff
`define FPCC_BIAS_SINGLE       13'h007f

`endif

// ### verilog/fpcc_slice.v
// Floating-point compare and ceiling-convert execution slice with AXI4-Lite status
//
// Overview of operation
// RULE_01: Selectors 0-7 quiet: F,UN,EQ,UEQ,OLT,ULT,OLE,ULE.
// RULE_02: Signalling bit set gives eight more compares.
// RULE_03: Signalling compares flag invalid on any NaN.
// RULE_04: Invalid exception taken only when enabled.
// RULE_05: Signalling selectors map SF,NGLE,SEQ,NGL,LT,NGE,LE,NGT.
// RULE_06: Eight condition bits; write only selected bit.
// RULE_07: Compare and branch carry condition select field.
// RULE_08: Condition zero mirrored on output and CSR.
// RULE_09: Software spaces compare and branch; unchecked.
// RULE_10: Signalling NaN operand always raises invalid.
// RULE_11: Ceiling to long, 64-bit, toward plus infinity.
// RULE_12: Ceiling to word, 32-bit, ignores rounding mode.
// RULE_13: Infinity, NaN or out-of-range is invalid.
// RULE_14: Invalid sets flag; enabled suppresses write, traps.
// RULE_15: Disabled invalid writes largest positive integer.
// RULE_16: Ceiling-to-long decoded by function 001010, second source zero.
// RULE_17: Ceiling-to-word decoded by function 001110, second source zero.
// RULE_18: Exactly one relation; NaN unordered; zeros equal.
// RULE_19: Enabled invalid compare writes no condition bit.
// RULE_20: Compare fields: select 10..8, 11 at 5..4, cond 3..0.
// RULE_21: Result is less, equal, unordered ANDed with selector.
// RULE_22: Ceiling sets inexact; unimplemented path supported.
`include "fpcc_consts.vh"

module fpcc_slice
(
    input  wire        clock,
    input  wire        rst_n,
    input  wire        issue_valid,
    input  wire [31:0] issue_instr,
    input  wire [63:0] source_fpr_a,
    input  wire [63:0] source_fpr_b,
    output reg         done,
    output reg         wb_valid,
    output reg  [4:0]  wb_dest_fpr,
    output reg  [63:0] wb_data,
    output reg         exc_valid,
    output reg         exc_invalid,
    output reg         exc_unimpl,
    output reg  [7:0]  fp_condition_bits,
    output reg         coproc_condition_output,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // NaN test in either width; single values sit in the low word
    function is_nan;
        input        dbl;
        input [63:0] v;
        begin
            if (dbl)
                is_nan = (v[62:52] == 11'h7ff) && (v[51:0] != 52'h0);
            else
                is_nan = (v[30:23] == 8'hff) && (v[22:0] != 23'h0);
        end
    endfunction

    // Signalling NaN has the quiet bit clear
    function is_snan;
        input        dbl;
        input [63:0] v;
        begin
            is_snan = is_nan(dbl, v) && !(dbl ? v[51] : v[22]);
        end
    endfunction

    // Magnitude without the sign, zero-extended to the double width
    function [62:0] magnitude;
        input        dbl;
        input [63:0] v;
        begin
            magnitude = dbl ? v[62:0] : {32'h0, v[30:0]};
        end
    endfunction

    // Instruction decode
    wire [4:0] fmt         = issue_instr[25:21];
    wire [5:0] func        = issue_instr[5:0];
    wire       is_fpu_op   = issue_instr[31:26] == `FPCC_OPC_COPROC_ONE;
    wire       fmt_dbl     = fmt == `FPCC_FMT_DOUBLE;
    wire       fmt_ok      = fmt_dbl || (fmt == `FPCC_FMT_SINGLE);
    wire       fmt_word_op = (fmt != 5'h08) && (fmt != 5'h06) && (fmt != 5'h04)
                             && (fmt != 5'h02) && (fmt != 5'h00);
    wire       is_cmp      = is_fpu_op && fmt_word_op                     // RULE_20
                             && (issue_instr[5:4] == `FPCC_CMP_TAG)
                             && (issue_instr[7:6] == `FPCC_CMP_ZERO);
    wire       src_b_zero  = issue_instr[20:16] == 5'h00;
    wire       is_ceil_l   = is_fpu_op && src_b_zero && (func == `FPCC_FUNC_CEIL_LONG); // RULE_16
    wire       is_ceil_w   = is_fpu_op && src_b_zero && (func == `FPCC_FUNC_CEIL_WORD); // RULE_17
    wire [2:0] cond_code_select = issue_instr[10:8];                      // RULE_07
    wire [3:0] cond        = issue_instr[3:0];
    wire [4:0] dest_fpr    = issue_instr[10:6];

    // Control/status state
    reg        flag_inexact;
    reg        flag_invalid;
    reg        flag_unimpl;
    reg        invalid_enable;

    // Ordering relations; NaN forces unordered, signed zeros equal
    wire        nan_a     = is_nan(fmt_dbl, source_fpr_a);
    wire        nan_b     = is_nan(fmt_dbl, source_fpr_b);
    wire        snan_any  = is_snan(fmt_dbl, source_fpr_a) || is_snan(fmt_dbl, source_fpr_b);
    wire        sign_a    = fmt_dbl ? source_fpr_a[63] : source_fpr_a[31];
    wire        sign_b    = fmt_dbl ? source_fpr_b[63] : source_fpr_b[31];
    wire [62:0] mag_a     = magnitude(fmt_dbl, source_fpr_a);
    wire [62:0] mag_b     = magnitude(fmt_dbl, source_fpr_b);
    wire        both_zero = (mag_a == 63'h0) && (mag_b == 63'h0);
    wire        unordered = nan_a || nan_b;                               // RULE_18
    wire        rel_equal = !unordered && (both_zero ||
                            ((mag_a == mag_b) && (sign_a == sign_b)));    // RULE_18
    wire        rel_less  = !unordered && !rel_equal &&
                            ((sign_a != sign_b) ? sign_a :
                             (sign_a ? (mag_a > mag_b) : (mag_a < mag_b)));
    // Same equation serves both selector groups
    wire        cmp_true  = (cond[2] && rel_less) || (cond[1] && rel_equal)
                            || (cond[0] && unordered);                    // RULE_21 RULE_01 RULE_05
    wire        cmp_inval = (cond[3] && unordered) || snan_any;           // RULE_02 RULE_03 RULE_10

    // Ceiling conversion datapath
    reg                cv_special;
    reg                cv_neg;
    reg                cv_hidden;
    reg signed [12:0]  cv_exp;
    reg        [52:0]  cv_mant;
    reg        [116:0] cv_big;
    reg        [64:0]  cv_int;
    reg                cv_frac;
    reg        [65:0]  cv_mag;
    reg        [65:0]  cv_limit;
    reg                cv_range;
    reg        [63:0]  cv_value;

    always @*
    begin
        cv_neg     = fmt_dbl ? source_fpr_a[63] : source_fpr_a[31];
        cv_special = fmt_dbl ? (source_fpr_a[62:52] == 11'h7ff)
                             : (source_fpr_a[30:23] == 8'hff);            // RULE_13
        cv_hidden  = fmt_dbl ? (source_fpr_a[62:52] != 11'h000)
                             : (source_fpr_a[30:23] != 8'h00);
        // Denormals use the minimum exponent; they always land below one
        if (fmt_dbl)
            cv_exp = $signed({2'b00, source_fpr_a[62:52]} | {12'h000, !cv_hidden})
                     - $signed(`FPCC_BIAS_DOUBLE);
        else
            cv_exp = $signed({5'h00, source_fpr_a[30:23]} | {12'h000, !cv_hidden})
                     - $signed(`FPCC_BIAS_SINGLE);
        cv_mant = fmt_dbl ? {cv_hidden, source_fpr_a[51:0]}
                          : {cv_hidden, source_fpr_a[22:0], 29'h0};
        cv_big  = {64'h0, cv_mant} << cv_exp[6:0];
        if (cv_exp < 13'sd0)
        begin
            cv_int  = 65'h0;
            cv_frac = cv_mant != 53'h0;
        end
        else
        begin
            cv_int  = cv_big[116:52];
            cv_frac = cv_big[51:0] != 52'h0;
        end
        // Round toward plus infinity: positive fractions step up
        cv_mag   = {1'b0, cv_int} + {65'h0, !cv_neg && cv_frac};           // RULE_11 RULE_12
        cv_limit = is_ceil_l ? `FPCC_LONG_LIMIT : `FPCC_WORD_LIMIT;
        cv_range = (cv_exp > 13'sd64) ||
                   (cv_neg ? (cv_mag > cv_limit) : (cv_mag >= cv_limit)); // RULE_13
        cv_value = cv_neg ? (64'h0 - cv_mag[63:0]) : cv_mag[63:0];
        if (!is_ceil_l)
            cv_value = {32'h0, cv_value[31:0]};
    end

    wire cv_inval = cv_special || cv_range;                               // RULE_13

    // Events of this issue cycle
    wire is_ceil    = is_ceil_l || is_ceil_w;
    wire unimpl_op  = issue_valid && (is_cmp || is_ceil) && !fmt_ok;      // RULE_22
    wire cmp_go     = issue_valid && is_cmp && fmt_ok;
    wire cv_go      = issue_valid && is_ceil && fmt_ok;
    wire set_inval  = (cmp_go && cmp_inval) || (cv_go && cv_inval);      // RULE_14
    wire set_inexact = cv_go && !cv_inval && cv_frac;                     // RULE_22
    wire trap_inval = set_inval && invalid_enable;                        // RULE_04

    // Bus slave state
    reg        aw_held;
    reg        w_held;
    reg [3:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    wire       do_write  = aw_held && w_held && !s_axi_bvalid;
    wire       csr_write = do_write && (aw_addr == `FPCC_ADDR_CSR) && w_strb[0];
    wire       en_write  = do_write && (aw_addr == `FPCC_ADDR_CSR) && w_strb[1];

    // Datapath results and condition bits
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done                    <= 1'b0;
            wb_valid                <= 1'b0;
            wb_dest_fpr             <= 5'h00;
            wb_data                 <= 64'h0;
            exc_valid               <= 1'b0;
            exc_invalid             <= 1'b0;
            exc_unimpl              <= 1'b0;
            fp_condition_bits       <= `FPCC_CONDS_RESET;
            coproc_condition_output <= 1'b0;
        end
        else
        begin
            done        <= cmp_go || cv_go || unimpl_op;
            wb_valid    <= cv_go && !trap_inval;                          // RULE_14
            wb_dest_fpr <= dest_fpr;
            wb_data     <= cv_inval ? (is_ceil_l ? `FPCC_LONG_MAX : `FPCC_WORD_MAX)
                                    : cv_value;                           // RULE_15
            exc_valid   <= trap_inval || unimpl_op;
            exc_invalid <= trap_inval;                                    // RULE_14 RULE_19
            exc_unimpl  <= unimpl_op;
            // A trapped compare leaves every condition bit alone
            if (cmp_go && !trap_inval)
            begin
                fp_condition_bits[cond_code_select] <= cmp_true;          // RULE_06 RULE_19
                if (cond_code_select == 3'h0)
                    coproc_condition_output <= cmp_true;                  // RULE_08
            end
        end
    end

    // Sticky flags: a hardware event wins over a software clear
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_inexact   <= `FPCC_CSR_RESET;
            flag_invalid   <= `FPCC_CSR_RESET;
            flag_unimpl    <= `FPCC_CSR_RESET;
            invalid_enable <= `FPCC_CSR_RESET;
        end
        else
        begin
            flag_inexact <= (csr_write ? w_data[`FPCC_CSR_INEXACT_FLAG] : flag_inexact)
                            | set_inexact;
            flag_invalid <= (csr_write ? w_data[`FPCC_CSR_INVALID_FLAG] : flag_invalid)
                            | set_inval;                                  // RULE_14
            flag_unimpl  <= (csr_write ? w_data[`FPCC_CSR_UNIMPL_FLAG] : flag_unimpl)
                            | unimpl_op;
            if (en_write)
                invalid_enable <= w_data[`FPCC_CSR_INVALID_EN];
        end
    end

    // Write channel: address and data taken in either order
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FPCC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // Condition register is read-only; writes there are accepted and dropped
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == `FPCC_ADDR_CSR || aw_addr == `FPCC_ADDR_CONDS)
                                ? `FPCC_RESP_OKAY : `FPCC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: one outstanding read, answer one cycle after address
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `FPCC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `FPCC_RESP_OKAY;
            s_axi_rdata   <= 32'h0;
            case (s_axi_araddr)
                `FPCC_ADDR_CSR:
                begin
                    s_axi_rdata[`FPCC_CSR_INEXACT_FLAG] <= flag_inexact;
                    s_axi_rdata[`FPCC_CSR_INVALID_FLAG] <= flag_invalid;
                    s_axi_rdata[`FPCC_CSR_UNIMPL_FLAG]  <= flag_unimpl;
                    s_axi_rdata[`FPCC_CSR_INVALID_EN]   <= invalid_enable;
                    s_axi_rdata[`FPCC_CSR_COND0]        <= fp_condition_bits[0]; // RULE_08
                end
                `FPCC_ADDR_CONDS:
                    s_axi_rdata[7:0] <= fp_condition_bits;
                default:
                    s_axi_rresp <= `FPCC_RESP_SLVERR;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ### verification/fpcc_monitor.sv
// Port-level timing and result checker for the compare and ceiling slice
module fpcc_monitor
(
    input wire        clock,
    input wire        rst_n,
    input wire        issue_valid,
    input wire [31:0] issue_instr,
    input wire        done,
    input wire        wb_valid,
    input wire [4:0]  wb_dest_fpr,
    input wire [63:0] wb_data,
    input wire        exc_valid,
    input wire        exc_invalid,
    input wire [7:0]  fp_condition_bits,
    input wire        coproc_condition_output
);
    timeunit 1ns;
    timeprecision 1ps;
    // Major opcode and single/double format share the top fmt bits
    wire op     = issue_instr[31:26] == 6'h11;
    wire fmt_ok = issue_instr[25:22] == 4'h8;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_cmp;
        issue_valid && op && fmt_ok && issue_instr[7:4] == 4'h3;
    endsequence
    // Both ceiling functions differ only in bit 2
    sequence s_ceil;
        issue_valid && op && fmt_ok && issue_instr[20:16] == 5'h0 &&
        issue_instr[5:3] == 3'h1 && issue_instr[1:0] == 2'h2;
    endsequence
    property p_cmp_done;
        s_cmp |=> done && !wb_valid;
    endproperty
    a_cmp_done: assert property (p_cmp_done) else $error("compare not completed");
    property p_ceil_done;
        s_ceil |=> done && (wb_valid != exc_valid);
    endproperty
    a_ceil_done: assert property (p_ceil_done) else $error("ceil not completed");
    property p_dest;
        s_ceil ##1 wb_valid |-> wb_dest_fpr == $past(issue_instr[10:6]);
    endproperty
    a_dest: assert property (p_dest) else $error("wrong destination");
    property p_word_zext;
        s_ceil ##1 (wb_valid && $past(issue_instr[2])) |-> wb_data[63:32] == 32'h0;
    endproperty
    a_word_zext: assert property (p_word_zext) else $error("word result not 32-bit");
    property p_cc_only;
        s_cmp |=> ((fp_condition_bits ^ $past(fp_condition_bits)) &
            ~(8'h1 << $past(issue_instr[10:8]))) == 8'h0;
    endproperty
    a_cc_only: assert property (p_cc_only) else $error("unselected bit changed");
    property p_mirror;
        coproc_condition_output == fp_condition_bits[0];
    endproperty
    a_mirror: assert property (p_mirror) else $error("condition output differs");
    property p_exc_nowb;
        exc_invalid |-> exc_valid && !wb_valid;
    endproperty
    a_exc_nowb: assert property (p_exc_nowb) else $error("write beside trap");
    property p_false;
        s_cmp ##0 issue_instr[2:0] == 3'h0 |=>
            exc_valid || !fp_condition_bits[$past(issue_instr[10:8])];
    endproperty
    a_false: assert property (p_false) else $error("false predicate true");
    property p_idle;
        !issue_valid || !op |=> !done && !wb_valid && !exc_valid && $stable(fp_condition_bits);
    endproperty
    a_idle: assert property (p_idle) else $error("output without instruction");
    cover property (s_ceil ##1 exc_invalid);
endmodule

bind fpcc_slice fpcc_monitor fpcc_monitor_inst (.clock, .rst_n, .issue_valid, .issue_instr,
    .done, .wb_valid, .wb_dest_fpr, .wb_data, .exc_valid, .exc_invalid, .fp_condition_bits,
    .coproc_condition_output);

// ### verification/fpcc_issue_model.sv
// Core-side issue model offering one instruction and its operands
module fpcc_issue_model
(
    input  wire         clock,
    output logic        issue_valid,
    output logic [31:0] issue_instr,
    output logic [63:0] source_fpr_a,
    output logic [63:0] source_fpr_b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        issue_valid = 1'b0;
        issue_instr = 32'h0;
        source_fpr_a = 64'h0;
        source_fpr_b = 64'h0;
    end
    // Idle cycle after every issue keeps compare-to-branch spacing
    task send(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b);
        @(posedge clock);
        issue_valid <= 1'b1;
        issue_instr <= i;
        source_fpr_a <= a;
        source_fpr_b <= b;
        @(posedge clock);
        // Inverted leftovers so stale operands never look live
        issue_valid <= 1'b0;
        issue_instr <= ~i;
        source_fpr_a <= ~a;
        source_fpr_b <= ~b;
    endtask
endmodule

// ### verification/fpcc_slice_tb_top.sv
// Self-checking bench for the compare and ceiling slice
`include "fpcc_consts.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module fpcc_slice_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0, rst_n = 0;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
    logic [31:0] s_axi_wdata = 0, rd;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [1:0]  rs;
    logic [3:0]  cv;
    logic        ex;
    wire         issue_valid, done, wb_valid, exc_valid, exc_invalid, exc_unimpl;
    wire         coproc_condition_output, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid;
    wire [31:0]  issue_instr, s_axi_rdata;
    wire [63:0]  source_fpr_a, source_fpr_b, wb_data;
    wire [4:0]   wb_dest_fpr;
    wire [7:0]   fp_condition_bits;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    int          err_count = 0, num_checks = 0;
    // Operand pairs: less, equal zeros, unordered, greater
    logic [63:0] opa[4] = '{64'h3ff0000000000000, 64'h0, 64'h7ff8000000000000,
                            64'h4000000000000000};
    logic [63:0] opb[4] = '{64'h4000000000000000, 64'h8000000000000000,
                            64'h3ff0000000000000, 64'h3ff0000000000000};
    logic [2:0]  rel[4] = '{3'h4, 3'h2, 3'h1, 3'h0};
    logic [3:0]  fc[3] = '{4'h7, 4'hf, 4'h0};
    logic [63:0] fa[3] = '{64'h7ff8000000000000, 64'h7ff8000000000000, 64'h7ff0000000000001};
    logic [31:0] fe[3] = '{32'h0, 32'h2, 32'h2};
    // Ceiling rows: 1.5, -1.5, inf, 2^31 single, -2^31, 2.5 single, 2^63
    logic [5:0]  cf[7] = '{6'h0a, 6'h0e, 6'h0a, 6'h0e, 6'h0e, 6'h0a, 6'h0a};
    logic [4:0]  cm[7] = '{5'h11, 5'h11, 5'h11, 5'h10, 5'h11, 5'h10, 5'h11};
    logic [63:0] cs[7] = '{64'h3ff8000000000000, 64'hbff8000000000000, 64'h7ff0000000000000,
                           64'h4f000000, 64'hc1e0000000000000, 64'h40200000,
                           64'h43e0000000000000};
    logic [63:0] ce[7] = '{64'h2, 64'hffffffff, `FPCC_LONG_MAX, `FPCC_WORD_MAX,
                           64'h80000000, 64'h3, `FPCC_LONG_MAX};
    logic [31:0] cg[7] = '{32'h1, 32'h1, 32'h2, 32'h2, 32'h0, 32'h1, 32'h2};
    logic [31:0] mi[3];
    logic [1:0]  me[3] = '{2'h3, 2'h0, 2'h0};
    fpcc_issue_model fpcc_issue_model_inst (.clock, .issue_valid, .issue_instr,
        .source_fpr_a, .source_fpr_b);
    fpcc_slice fpcc_slice_inst (.clock, .rst_n, .issue_valid, .issue_instr, .source_fpr_a,
        .source_fpr_b, .done, .wb_valid, .wb_dest_fpr, .wb_data, .exc_valid, .exc_invalid,
        .exc_unimpl, .fp_condition_bits, .coproc_condition_output, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    initial
    begin
        forever #20 clock = ~clock;
    end
    task wrap_up;
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Write: address and data offered together, each dropped when taken
    task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (1)
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
            n++;
            if (n > 50) begin err_count++; wrap_up; end
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (1)
        begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
            n++;
            if (n > 50) begin err_count++; wrap_up; end
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function logic [31:0] cmpi(logic [4:0] f, logic [2:0] sel, logic [3:0] c);
        return {6'h11, f, 10'h0, sel, 4'h3, c};
    endfunction
    function logic [31:0] ceili(logic [4:0] f, logic [5:0] fn, logic [4:0] dst);
        return {6'h11, f, 10'h0, dst, fn};
    endfunction
    // Main sequence: registers, predicates, flags, traps, conversions, decode
    initial
    begin
        mi = '{ceili(5'h14, 6'h0a, 5'h0), ceili(5'h11, 6'h0e, 5'h0) | 32'h10000, 32'h48000000};
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        axi_rd(`FPCC_ADDR_CSR, rd, rs);
        `CHK("csr_reset", 32'h0, rd)
        axi_rd(`FPCC_ADDR_CONDS, rd, rs);
        `CHK("cond_reset", 32'h0, rd)
        axi_rd(4'h8, rd, rs);
        `CHK("rd_unmapped", `FPCC_RESP_SLVERR, rs)
        axi_wr(4'h8, 32'hffff, rs);
        `CHK("wr_unmapped", `FPCC_RESP_SLVERR, rs)
        for (int k = 0; k < 4; k++)
            for (int c = 0; c < 16; c++)
            begin
                cv = c[3:0];
                ex = (cv[2] & rel[k][2]) | (cv[1] & rel[k][1]) | (cv[0] & rel[k][0]);
                fpcc_issue_model_inst.send(cmpi(`FPCC_FMT_DOUBLE, cv[2:0], cv), opa[k], opb[k]);
                #1;
                `CHK("cond", ex, fp_condition_bits[cv[2:0]])
                `CHK("cmp_exc", 1'b0, exc_valid)
                if (cv[2:0] == 3'h0) `CHK("cond_out", ex, coproc_condition_output)
            end
        // Single format: 1.0 less than 2.0 into condition bit 5
        fpcc_issue_model_inst.send(cmpi(`FPCC_FMT_SINGLE, 3'h5, 4'h4), 64'h3f800000,
                                   64'h40000000);
        #1;
        `CHK("cond_single", 1'b1, fp_condition_bits[5])
        for (int i = 0; i < 3; i++)
        begin
            axi_wr(`FPCC_ADDR_CSR, 32'h0, rs);
            fpcc_issue_model_inst.send(cmpi(`FPCC_FMT_DOUBLE, 3'h0, fc[i]), fa[i], opb[3]);
            axi_rd(`FPCC_ADDR_CSR, rd, rs);
            `CHK("inv_flag", fe[i], rd & 32'h7)
            `CHK("csr_cond0", fc[i][0], rd[23])
        end
        axi_wr(`FPCC_ADDR_CSR, 32'h100, rs);
        fpcc_issue_model_inst.send(cmpi(`FPCC_FMT_DOUBLE, 3'h3, 4'hb), fa[0], opb[3]);
        #1;
        `CHK("cmp_trap", 1'b1, exc_invalid)
        `CHK("cmp_nowrite", 1'b0, fp_condition_bits[3])
        fpcc_issue_model_inst.send(ceili(`FPCC_FMT_DOUBLE, `FPCC_FUNC_CEIL_LONG, 5'h1), cs[2], 0);
        #1;
        `CHK("ceil_trap", 2'h1, {wb_valid, exc_invalid})
        for (int i = 0; i < 7; i++)
        begin
            axi_wr(`FPCC_ADDR_CSR, 32'h0, rs);
            fpcc_issue_model_inst.send(ceili(cm[i], cf[i], i[4:0]), cs[i], 64'h0);
            #1;
            `CHK("ceil_wb", 1'b1, wb_valid)
            `CHK("ceil_data", ce[i], wb_data)
            `CHK("ceil_dest", i[4:0], wb_dest_fpr)
            axi_rd(`FPCC_ADDR_CSR, rd, rs);
            `CHK("ceil_flags", cg[i], rd & 32'h7)
        end
        for (int i = 0; i < 3; i++)
        begin
            fpcc_issue_model_inst.send(mi[i], cs[0], 64'h0);
            #1;
            `CHK("decode", me[i], {done, exc_unimpl})
        end
        wrap_up;
    end
endmodule
